// file: shared/phy_status_map.vh
// register offsets, field positions and reset values of the quick status block
`ifndef PHY_STATUS_MAP_VH
`define PHY_STATUS_MAP_VH

// byte addresses on the avalon slave
`define QS_ADDR_STATUS     4'h0
`define QS_ADDR_CONTROL    4'h4
`define QS_ADDR_IRQ_STAT   4'h8
`define QS_ADDR_IRQ_CLEAR  4'hc
`define QS_ADDR_IRQ_ENABLE 4'h0
`define QS_ADDR_AW         4
`define QS_ADDR_ENABLE_B   5'h10

// quick status bit positions
`define QS_BIT_RSVD        15
`define QS_BIT_SWAP        14
`define QS_BIT_RXERR       13
`define QS_BIT_POL         12
`define QS_BIT_FCAR        11
`define QS_BIT_SDET        10
`define QS_BIT_LOCK        9
`define QS_BIT_PAGE        8
`define QS_BIT_IRQ         7

// control register bit positions
`define CTL_BIT_AUTO       0
`define CTL_BIT_FORCE      1
`define CTL_BIT_QUAL       2
`define CTL_RESET          3'h1

// clear-on-read strobes, one per source register
`define CLR_RXERR          0
`define CLR_POL            1
`define CLR_FCAR           2
`define CLR_PAGE           3
`define CLR_IRQ            4
`define CLR_LOCK           5

// event status bits
`define EV_RXERR           0
`define EV_FCAR            1
`define EV_LOCK_LOSS       2
`define EV_PAGE            3
`define EV_W               4

`define READ_ZERO          32'h0000_0000
`endif

// file: src/phy_quick_status.v
// quick status word of one transceiver port with its avalon slave
`timescale 1ns/10ps
//
// Function
// - bit 15 ignores writes and always reads zero.
// - pair swap bit is 1 when receive uses the transmit pair.
// - with auto crossover on and not forced, swap bit tracks algorithm live.
// - receive-error latch sets on any error, clears on error counter read.
// - polarity bit mirrors inverted-polarity flag, clears on its source read.
// - false-carrier latch sets on any event, clears on counter read.
// - signal detect reported latch-low like lock: raw detect, ANDed with lock when qualifier is set.
// - descrambler lock reported latch-low, loss held at zero until seen.
// - page-received copies expansion flag, cleared only by expansion read.
// - interrupt-pending bit high while internal interrupt outstanding.
`include "phy_status_map.vh"

module phy_quick_status (
  input  wire        clk_in,
  input  wire        rst_in,
  // avalon-mm slave
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  // sources from the port logic, outside this clock domain
  input  wire        pair_swap_algo_in,
  input  wire        rx_error_event_in,
  input  wire        polarity_inverted_in,
  input  wire        false_carrier_event_in,
  input  wire        signal_detect_raw_in,
  input  wire        descrambler_lock_in,
  input  wire        page_received_in,
  input  wire        internal_irq_in,
  // clearing reads of the source registers, same clock
  input  wire [5:0]  source_read_in,
  output reg  [15:0] phy_quick_status_out,
  output reg         irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for all port-side sources
  reg  [7:0] sync_a;
  reg  [7:0] sync_b;
  wire [7:0] raw_src = {internal_irq_in, page_received_in, descrambler_lock_in,
                        signal_detect_raw_in, false_carrier_event_in,
                        polarity_inverted_in, rx_error_event_in,
                        pair_swap_algo_in};

  always @(posedge clk_in) begin
    if (rst_in) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= raw_src;
      sync_b <= sync_a;
    end
  end

  wire s_swap  = sync_b[0];
  wire s_rxerr = sync_b[1];
  wire s_pol   = sync_b[2];
  wire s_fcar  = sync_b[3];
  wire s_sdraw = sync_b[4];
  wire s_lock  = sync_b[5];
  wire s_page  = sync_b[6];
  wire s_irq   = sync_b[7];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [2:0]       control;
  reg  [`EV_W-1:0] ev_status;
  reg  [`EV_W-1:0] ev_enable;
  reg              rxerr_latch;
  reg              fcar_latch;
  reg              pol_flag;
  reg              page_flag;
  reg              irq_flag;
  reg              lock_ll;
  reg              sdet_ll;
  reg              lock_armed;

  wire auto_en = control[`CTL_BIT_AUTO];
  wire force_x = control[`CTL_BIT_FORCE];
  wire qual_en = control[`CTL_BIT_QUAL];

  // live swap when auto and not forced, else forced setting
  wire swap_now = (auto_en && !force_x) ? s_swap : force_x;
  wire sdet_now = qual_en ? (s_sdraw & s_lock) : s_sdraw;

  // latch-low: set wins toward zero; read re-arms to live value
  function latch_low;
    input cur;
    input live;
    input clr;
    begin
      latch_low = clr ? live : (cur & live);
    end
  endfunction

  // sticky set: set wins over clear
  function latch_high;
    input cur;
    input set;
    input clr;
    begin
      latch_high = set | (cur & ~clr);
    end
  endfunction

  wire acc       = avs_read_in | avs_write_in;
  wire take      = acc & avs_waitrequest_out;
  // write lands at the edge where the master sees waitrequest low
  wire wr_take   = avs_write_in & ~avs_waitrequest_out;
  wire lock_fall = lock_armed & ~s_lock;

  always @(posedge clk_in) begin
    if (rst_in) begin
      rxerr_latch <= 1'b0;
      fcar_latch  <= 1'b0;
      pol_flag    <= 1'b0;
      page_flag   <= 1'b0;
      irq_flag    <= 1'b0;
      lock_ll     <= 1'b0;
      sdet_ll     <= 1'b0;
      lock_armed  <= 1'b0;
    end else begin
      rxerr_latch <= latch_high(rxerr_latch, s_rxerr, source_read_in[`CLR_RXERR]);
      fcar_latch  <= latch_high(fcar_latch, s_fcar, source_read_in[`CLR_FCAR]);
      pol_flag    <= latch_high(pol_flag, s_pol, source_read_in[`CLR_POL]);
      page_flag   <= latch_high(page_flag, s_page, source_read_in[`CLR_PAGE]);
      irq_flag    <= latch_high(irq_flag, s_irq, source_read_in[`CLR_IRQ]);
      lock_ll     <= latch_low(lock_ll, s_lock, source_read_in[`CLR_LOCK]);
      sdet_ll     <= latch_low(sdet_ll, sdet_now, source_read_in[`CLR_LOCK]);
      lock_armed  <= s_lock;
    end
  end

  wire [15:0] status_word;
  assign status_word[`QS_BIT_RSVD]  = 1'b0;
  assign status_word[`QS_BIT_SWAP]  = swap_now;
  assign status_word[`QS_BIT_RXERR] = rxerr_latch;
  assign status_word[`QS_BIT_POL]   = pol_flag;
  assign status_word[`QS_BIT_FCAR]  = fcar_latch;
  assign status_word[`QS_BIT_SDET]  = sdet_ll;
  assign status_word[`QS_BIT_LOCK]  = lock_ll;
  assign status_word[`QS_BIT_PAGE]  = page_flag;
  assign status_word[`QS_BIT_IRQ]   = irq_flag;
  assign status_word[6:0]           = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // event status, enable and clear
  wire [`EV_W-1:0] ev_set;
  assign ev_set[`EV_RXERR]     = s_rxerr;
  assign ev_set[`EV_FCAR]      = s_fcar;
  assign ev_set[`EV_LOCK_LOSS] = lock_fall;
  assign ev_set[`EV_PAGE]      = s_page & ~page_flag;

  wire in_hi = avs_address_in[4];
  wire [3:0] lo = avs_address_in[3:0];

  always @(posedge clk_in) begin
    if (rst_in) begin
      control   <= `CTL_RESET;
      ev_status <= {`EV_W{1'b0}};
      ev_enable <= {`EV_W{1'b0}};
    end else begin
      if (wr_take && !in_hi && lo == `QS_ADDR_CONTROL)
        control <= avs_writedata_in[2:0];
      if (wr_take && in_hi && lo == `QS_ADDR_IRQ_ENABLE)
        ev_enable <= avs_writedata_in[`EV_W-1:0];
      if (wr_take && !in_hi && lo == `QS_ADDR_IRQ_CLEAR)
        ev_status <= ev_set | (ev_status & ~avs_writedata_in[`EV_W-1:0]);
      else
        ev_status <= ev_set | ev_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon answer: one wait cycle, data registered
  reg [31:0] next_readdata;

  always @* begin
    next_readdata = `READ_ZERO;
    if (in_hi) begin
      if (lo == `QS_ADDR_IRQ_ENABLE)
        next_readdata = {28'h0000000, ev_enable};
    end else begin
      case (lo)
        `QS_ADDR_STATUS:   next_readdata = {16'h0000, status_word};
        `QS_ADDR_CONTROL:  next_readdata = {29'h00000000, control};
        `QS_ADDR_IRQ_STAT: next_readdata = {28'h0000000, ev_status};
        default:           next_readdata = `READ_ZERO;
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out  <= 1'b1;
      avs_readdata_out     <= `READ_ZERO;
      phy_quick_status_out <= 16'h0000;
      irq_out              <= 1'b0;
    end else begin
      avs_waitrequest_out <= ~(acc & avs_waitrequest_out);
      if (take && avs_read_in)
        avs_readdata_out <= next_readdata;
      phy_quick_status_out <= status_word;
      irq_out <= |(ev_status & ev_enable);
    end
  end

endmodule // phy_quick_status

// file: testbench/phy_quick_status_properties.sv
// checker on the quick status ports
`timescale 1ns/10ps
module phy_quick_status_properties (
  input logic        clk_in,
  input logic        rst_in,
  input logic        avs_read_in,
  input logic        avs_write_in,
  input logic        avs_waitrequest_out,
  input logic [5:0]  source_read_in,
  input logic [15:0] phy_quick_status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire [15:0] s = phy_quick_status_out;
  wire [5:0]  r = source_read_in;
  chk_rsvd_zero: assert property (s[15] == 1'b0)
    else $error("reserved bit set");
  chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered");
  chk_rxerr_hold: assert property (s[13] && !r[0] && !$past(r[0]) |=> s[13])
    else $error("rx error latch dropped");
  chk_fcar_hold: assert property (s[11] && !r[2] && !$past(r[2]) |=> s[11])
    else $error("false carrier latch dropped");
  chk_page_hold: assert property (s[8] && !r[3] && !$past(r[3]) |=> s[8])
    else $error("page flag dropped");
  chk_lock_low: assert property (!s[9] && !r[5] && !$past(r[5]) |=> !s[9])
    else $error("lock rose without read");
  chk_detect_low: assert property (!s[10] && !r[5] && !$past(r[5]) |=> !s[10])
    else $error("detect rose without read");
endmodule // phy_quick_status_properties
bind phy_quick_status phy_quick_status_properties u_props (.clk_in, .rst_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .source_read_in, .phy_quick_status_out);

// file: testbench/tb.sv
// self-checking bench of the quick status block
`timescale 1ns/10ps
`define CHK(a,e) begin compares++; if ((a) !== (e)) begin fails++; $display("BAD %0t %h", $time, a); end end
module tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        rd     = 1'b0;
  logic        wr     = 1'b0;
  logic [4:0]  adr    = 5'h00;
  logic [31:0] wd     = 32'h0000_0000;
  logic [31:0] rdata;
  logic [1:0]  ev     = 2'h0;
  logic [5:0]  lv     = 6'h00;
  logic [5:0]  srd    = 6'h00;
  wire  [31:0] dout;
  wire         wq;
  wire  [15:0] st;
  wire         irq;
  int          fails = 0;
  int          compares = 0;
  phy_quick_status u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(dout),
    .avs_waitrequest_out(wq), .pair_swap_algo_in(lv[0]), .rx_error_event_in(ev[0]),
    .polarity_inverted_in(lv[1]), .false_carrier_event_in(ev[1]),
    .signal_detect_raw_in(lv[2]), .descrambler_lock_in(lv[3]), .page_received_in(lv[4]),
    .internal_irq_in(lv[5]), .source_read_in(srd), .phy_quick_status_out(st), .irq_out(irq));
  task automatic cyc(int n); repeat (n) @(posedge clk_in); endtask
  task automatic pulse(int c); srd[c] <= 1'b1; cyc(1); srd[c] <= 1'b0; endtask
  task automatic bus(bit w, logic [4:0] a, logic [31:0] d);
    adr <= a; wd <= d; rd <= !w; wr <= w;
    do @(posedge clk_in); while (wq !== 1'b0);
    rdata = dout;
    rd <= 1'b0; wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic t_reset;
    bus(0, 5'h00, 0); `CHK(rdata, 32'h0)
    bus(1, 5'h00, 32'hffff); bus(0, 5'h00, 0); `CHK(rdata[15], 1'b0)
    bus(0, 5'h04, 0); `CHK(rdata, 32'h1)
    bus(0, 5'h14, 0); `CHK(rdata, 32'h0)
  endtask
  task automatic t_swap;
    lv[0] <= 1'b1; cyc(6); bus(0, 5'h00, 0); `CHK(rdata[14], 1'b1)
    lv[0] <= 1'b0; cyc(6); bus(0, 5'h00, 0); `CHK(rdata[14], 1'b0)
    bus(1, 5'h04, 2); bus(0, 5'h00, 0); `CHK(rdata[14], 1'b1)
    lv[0] <= 1'b1; bus(1, 5'h04, 0); cyc(6); bus(0, 5'h00, 0); `CHK(rdata[14], 1'b0)
    lv[0] <= 1'b0; bus(1, 5'h04, 1);
  endtask
  task automatic t_latch(int i, int b, int c);
    bus(1, 5'h10, {31'h0, i == 0});
    ev[i] <= 1'b1; cyc(2); ev[i] <= 1'b0; cyc(6);
    bus(0, 5'h00, 0); `CHK(rdata[b], 1'b1)
    `CHK(irq, i == 0)
    bus(0, 5'h08, 0); `CHK(rdata[i], 1'b1)
    bus(1, 5'h0c, 32'h1 << i); cyc(2); `CHK(irq, 1'b0)
    pulse(c); cyc(3); bus(0, 5'h00, 0); `CHK(rdata[b], 1'b0)
  endtask
  task automatic t_mirror(int l, int b, int c);
    lv[l] <= 1'b1; cyc(6); bus(0, 5'h00, 0);
    bus(0, 5'h00, 0); `CHK(rdata[b], 1'b1)
    lv[l] <= 1'b0; cyc(4); pulse(c); cyc(2);
    bus(0, 5'h00, 0); `CHK(rdata[b], 1'b0)
  endtask
  task automatic t_low;
    lv[2] <= 1'b1; lv[3] <= 1'b1; cyc(4); pulse(5); cyc(6);
    bus(0, 5'h00, 0); `CHK(rdata[10:9], 2'b11)
    lv[3] <= 1'b0; cyc(4); lv[3] <= 1'b1; cyc(6);
    bus(0, 5'h00, 0); `CHK(rdata[10:9], 2'b10)
    bus(0, 5'h08, 0); `CHK(rdata[2], 1'b1)
    pulse(5); cyc(6); bus(0, 5'h00, 0); `CHK(rdata[9], 1'b1)
    bus(1, 5'h04, 5); lv[3] <= 1'b0; cyc(4); pulse(5); cyc(6);
    bus(0, 5'h00, 0); `CHK(rdata[10], 1'b0)
  endtask
  task automatic complete_run;
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset; t_swap; t_latch(0, 13, 0); t_latch(1, 11, 2);
    t_mirror(1, 12, 1); t_mirror(4, 8, 3); t_mirror(5, 7, 4); t_low;
    complete_run;
  end
  initial begin
    #100000;
    fails++;
    complete_run;
  end
endmodule // tb
